// >>> fractional_pll_clock_config.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// Contract
// RULE1: software keeps integer multiplier within 6 to 12
// RULE2: fraction is 24-bit unsigned, value over 2^24 added to integer
// RULE3: software rounds fractional ratio times 2^24 to nearest integer
// RULE4: fraction bytes: first 23:16, second 15:8, third 7:0
// RULE5: integer multiplier in control bits 3:0, whole part of ratio
// RULE6: control bit 4 selects reference direct or divided by two
// RULE7: master divisor bits 4:2 give 1,1.5,2,3,4,6,8,12
// RULE8: software sets dividers for 24.576MHz master, 98.304MHz oscillator
// RULE9: aux output equals synthesizer frequency over aux divisor plus one
// RULE10: divider bit 5 selects dac oversampling high when set
// RULE11: divider bit 6 selects microphone clock 64kHz, else 32kHz
// RULE12: bypass routes reference clock straight to core clock node
// RULE13: control bit 7 enables the synthesizer
// RULE14: software clears frame-lock and sets bypass before disabling synthesizer
// RULE15: software never enables frame-lock while synthesizer is off
// RULE16: software truncates ratio to obtain integer multiplier
// RULE17: read-only status bit shows synthesizer locked
// RULE18: frame-lock enable locks master clock to frame sync, needs synthesizer
// RULE19: synthesizer output passes fixed divide-by-four before master divisor
// RULE20: lock drops on setting change, returns after settling
module fractional_pll_clock_config
  import pll_cfg_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic        pclk,               // bus clock, 40 MHz
  input  wire logic        presetn,            // async reset, low
  input  wire logic        ce,                 // clock enable, freezes state
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb enable
  input  wire logic        pwrite,             // apb direction
  input  wire logic [11:0] paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  input  wire logic        ref_clock_in,       // reference clock pin
  input  wire logic        synth_clk_tick,     // oscillator output tick (analog)
  output logic      [31:0] prdata,             // apb read data
  output logic             pready,             // apb ready
  output logic             pslverr,            // apb error
  output logic      [3:0]  mult_int,           // integer multiplier to core
  output logic      [23:0] mult_fraction,      // fraction to core
  output logic             synth_enable,       // oscillator enable
  output logic             ref_div2,           // prescaler select
  output logic             core_clock_node,    // core clock
  output logic             internal_master_clock, // master clock
  output logic             aux_out_clk,        // general-purpose clock out
  output logic             dac_oversample_sel, // dac oversampling high
  output logic             mic_sample_rate_sel,// mic 64kHz when high
  output logic             frame_lock_loop_on, // frame-lock loop enable
  output logic             synth_locked        // lock status
);
  // ==========================================================================
  // elaboration checks
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("settle count must be at least one");
  end
  // the settle counter is sixteen bits wide
  if (SETTLE_CYCLES > 65536) begin : g_big_settle
    $error("settle count exceeds counter range");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]  clk_div;
    logic [23:0] frac;
    logic [7:0]  ctrl;
    logic [7:0]  clkctl;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [1:0]  ref_sync;
    logic        ref_q;
    logic        ref_half;
    logic [15:0] settle;
    logic        locked;
    logic [1:0]  aux_cnt;
    logic        aux_q;
    logic        fll_q;
    logic        core_q;
    logic        mclk_frac;
    logic [3:0]  out_vec;
  } st_t;
  st_t s_r, s_nxt;

  logic       acc;
  logic       wr;
  logic [9:0] idx;
  logic       mapped;
  logic       lock_restart;
  logic [4:0] mclk_half;
  logic       mclk_wire;
  logic       ref_edge;

  // apb access phase; slave answers with pready in the cycle after the first access cycle
  assign acc = psel && penable && !s_r.ready;
  assign wr  = acc && pwrite;
  assign idx = paddr[11:2];

  always_comb begin
    case (idx[7:0])
      IDX_CLK_DIV, IDX_FRAC_HI, IDX_FRAC_MID, IDX_FRAC_LO, IDX_SYNTH_CTRL,
      IDX_CLOCK_CTRL, IDX_STATUS: mapped = (idx[9:8] == 2'b00);
      default:                    mapped = 1'b0;
    endcase
  end

  // master divisor as half periods in oscillator ticks: the fixed divide by
  // four is folded in, so 1.5 needs no fractional count (half = 2 * divisor)
  always_comb begin
    case (s_r.clk_div[MCLK_DIV_LSB +: 3]) // RULE7 RULE19
      3'd0:    mclk_half = 5'd2;
      3'd1:    mclk_half = 5'd3;
      3'd2:    mclk_half = 5'd4;
      3'd3:    mclk_half = 5'd6;
      3'd4:    mclk_half = 5'd8;
      3'd5:    mclk_half = 5'd12;
      3'd6:    mclk_half = 5'd16;
      default: mclk_half = 5'd24;
    endcase
  end

  // a change of enable, prescaler, integer or fraction restarts settling
  always_comb begin
    lock_restart = 1'b0;
    if (wr && mapped) begin
      case (idx[7:0])
        IDX_FRAC_HI, IDX_FRAC_MID, IDX_FRAC_LO: lock_restart = 1'b1; // RULE20
        IDX_SYNTH_CTRL: lock_restart =
          (pwdata[7:0] & 8'h9F) != (s_r.ctrl & 8'h9F); // RULE20
        default: lock_restart = 1'b0;
      endcase
    end
  end

  assign ref_edge = s_r.ref_sync[1] & ~s_r.ref_q;

  // next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ready = acc;
    s_nxt.err   = acc && !mapped;
    s_nxt.rdata = '0;
    // register writes
    if (wr && mapped) begin
      case (idx[7:0])
        IDX_CLK_DIV:    s_nxt.clk_div = {1'b0, pwdata[6:0]};
        IDX_FRAC_HI:    s_nxt.frac[23:16] = pwdata[7:0]; // RULE4
        IDX_FRAC_MID:   s_nxt.frac[15:8]  = pwdata[7:0]; // RULE4
        IDX_FRAC_LO:    s_nxt.frac[7:0]   = pwdata[7:0]; // RULE4
        IDX_SYNTH_CTRL: s_nxt.ctrl = pwdata[7:0] & 8'hDF;
        IDX_CLOCK_CTRL: s_nxt.clkctl = pwdata[7:0];
        default:        s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    // register reads
    if (acc && !pwrite && mapped) begin
      case (idx[7:0])
        IDX_CLK_DIV:    s_nxt.rdata = {24'h00_0000, s_r.clk_div};
        IDX_FRAC_HI:    s_nxt.rdata = {24'h00_0000, s_r.frac[23:16]};
        IDX_FRAC_MID:   s_nxt.rdata = {24'h00_0000, s_r.frac[15:8]};
        IDX_FRAC_LO:    s_nxt.rdata = {24'h00_0000, s_r.frac[7:0]};
        IDX_SYNTH_CTRL: s_nxt.rdata = {24'h00_0000, s_r.ctrl};
        IDX_CLOCK_CTRL: s_nxt.rdata = {24'h00_0000, s_r.clkctl};
        default:        s_nxt.rdata = {24'h00_0000, s_r.locked, 7'h00}; // RULE17
      endcase
    end
    // reference pin sync and optional divide-by-two
    s_nxt.ref_sync = {s_r.ref_sync[0], ref_clock_in};
    s_nxt.ref_q    = s_r.ref_sync[1];
    if (ref_edge) begin
      s_nxt.ref_half = ~s_r.ref_half; // RULE6
    end
    // lock settling counter
    if (!s_r.ctrl[ENABLE_BIT] || lock_restart) begin
      s_nxt.settle = '0;
      s_nxt.locked = 1'b0; // RULE20
    end else if (32'(s_r.settle) + 1 >= SETTLE_CYCLES) begin
      s_nxt.locked = 1'b1; // RULE17
    end else begin
      s_nxt.settle = s_r.settle + 16'd1;
    end
    // aux clock: one pulse every divisor+1 oscillator ticks, so its edge
    // rate is the oscillator rate over divisor+1; a toggling divider could
    // not reach divisor zero
    s_nxt.aux_q = 1'b0;
    if (!s_r.ctrl[ENABLE_BIT]) begin
      s_nxt.aux_cnt = '0;
    end else if (synth_clk_tick) begin
      if (s_r.aux_cnt >= s_r.clk_div[AUX_DIV_LSB +: 2]) begin
        s_nxt.aux_cnt = '0;
        s_nxt.aux_q   = 1'b1; // RULE9
      end else begin
        s_nxt.aux_cnt = s_r.aux_cnt + 2'd1;
      end
    end
    // core clock node: bypass takes the pin, else the oscillator
    s_nxt.core_q = s_r.ctrl[BYPASS_BIT] ? s_r.ref_sync[1] // RULE12
                 : (s_r.ctrl[ENABLE_BIT] && synth_clk_tick);
    s_nxt.out_vec = {mclk_wire, s_r.aux_q,
                     s_r.clk_div[OSR_BIT], s_r.clk_div[MIC_BIT]}; // RULE10 RULE11
    // frame-lock output registered from the next register values
    s_nxt.fll_q = s_nxt.clkctl[FLL_BIT] & s_nxt.ctrl[ENABLE_BIT]; // RULE18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r         <= '0;
      s_r.clk_div <= RST_CLK_DIV;
      s_r.frac    <= RST_FRAC;
      s_r.ctrl    <= RST_SYNTH_CTRL;
      s_r.clkctl  <= RST_CLOCK_CTRL;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // master clock divider after the fixed divide-by-four
  clk_div_gen #(.W(5)) u_mclk (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (s_r.ctrl[ENABLE_BIT]),
    .half_cnt(mclk_half),
    .tick    (synth_clk_tick),
    .clk_out (mclk_wire)
  );

  // outputs straight from flip-flops
  assign prdata                = s_r.rdata;
  assign pready                = s_r.ready;
  assign pslverr               = s_r.err;
  assign mult_int              = s_r.ctrl[DIV_N_LSB +: 4];           // RULE5 RULE2
  assign mult_fraction         = s_r.frac;                           // RULE2
  assign synth_enable          = s_r.ctrl[ENABLE_BIT];               // RULE13
  assign ref_div2              = s_r.ctrl[PRESC_BIT];                // RULE6
  assign frame_lock_loop_on    = s_r.fll_q;                          // RULE18
  assign core_clock_node       = s_r.core_q;
  assign internal_master_clock = s_r.out_vec[3];
  assign aux_out_clk           = s_r.out_vec[2];
  assign dac_oversample_sel    = s_r.out_vec[1];
  assign mic_sample_rate_sel   = s_r.out_vec[0];
  assign synth_locked          = s_r.locked;

  // ==========================================================================
  // assertions
  a_lock_drops_on_change: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    (ce && lock_restart) |=> !synth_locked) else $error("lock held after change");
  a_lock_needs_enable: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    synth_locked |-> synth_enable) else $error("locked while disabled");
  a_frac_byte_hi: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (ce && wr && idx == 10'h041) |=> mult_fraction[23:16] == $past(pwdata[7:0]))
    else $error("fraction high byte wrong");
  a_int_field: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (ce && wr && idx == 10'h044) |=> mult_int == $past(pwdata[3:0]))
    else $error("integer field wrong");
  a_fll_needs_synth: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    frame_lock_loop_on |-> synth_enable) else $error("frame lock without synth");
  a_apb_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && acc) |=> pready ##1 (!pready || !ce)) else $error("ready not single");
  a_bypass_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (ce && s_r.ctrl[BYPASS_BIT]) |=> core_clock_node == $past(s_r.ref_sync[1]))
    else $error("bypass not routed");
  a_osr_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    ce |=> dac_oversample_sel == $past(s_r.clk_div[OSR_BIT]))
    else $error("oversampling select wrong");
  a_mic_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    ce |=> mic_sample_rate_sel == $past(s_r.clk_div[MIC_BIT]))
    else $error("mic select wrong");
  a_enable_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    (ce && wr && idx == 10'h044) |=> synth_enable == $past(pwdata[7]))
    else $error("enable bit wrong");
  a_mclk_code: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (s_r.clk_div[4:2] == 3'd7) |-> mclk_half == 5'd24) else $error("divisor wrong");

  // ==========================================================================
  // sequences for the multi-step checks
  // an access phase that the slave takes at this edge
  sequence s_apb_taken;
    ce && psel && penable && !pready;
  endsequence

  // an oscillator tick that completes an aux period
  sequence s_aux_wrap;
    ce && synth_clk_tick && s_r.ctrl[ENABLE_BIT]
      && (s_r.aux_cnt >= s_r.clk_div[AUX_DIV_LSB +: 2]);
  endsequence

  // enabled, unchanged and at the end of the settle count
  sequence s_settle_done;
    ce && s_r.ctrl[ENABLE_BIT] && !lock_restart
      && (32'(s_r.settle) + 1 >= SETTLE_CYCLES);
  endsequence

  // a reference edge seen behind the synchroniser
  sequence s_ref_edge;
    ce && ref_edge;
  endsequence

  // ==========================================================================
  // further assertions
  // every taken access is answered in the next cycle
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_taken |=> pready) else $error("access not answered");
  // unmapped index answers with error and zero data
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && acc && !mapped) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  // refused writes leave the control register alone
  a_no_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && wr && !mapped) |=> $stable(s_r.ctrl)) else $error("stray write landed");
  // aux pulse follows every completed period
  a_aux_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    s_aux_wrap |=> s_r.aux_q) else $error("aux pulse missing");
  // no aux pulse without an oscillator tick
  a_aux_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (ce && !synth_clk_tick) |=> !s_r.aux_q) else $error("aux pulse without tick");
  // lock reached once the settle count runs out
  a_lock_settles: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    s_settle_done |=> synth_locked) else $error("lock not reached");
  // prescaler half-rate reference flips on each edge
  a_presc_toggle: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    s_ref_edge |=> s_r.ref_half != $past(s_r.ref_half)) else $error("prescaler stuck");
  // second synchroniser stage follows the first
  a_ref_sync_pair: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> s_r.ref_sync[1] == $past(s_r.ref_sync[0])) else $error("sync chain broken");
  // frame-lock output tracks its enable and the synthesizer enable
  a_fll_follow: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    ce |=> frame_lock_loop_on == (s_r.clkctl[FLL_BIT] && s_r.ctrl[ENABLE_BIT]))
    else $error("frame lock output wrong");
  // clock enable low holds every register
  a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(s_r)) else $error("state moved with enable low");
endmodule : fractional_pll_clock_config

// >>> pll_cfg_pkg.sv
package pll_cfg_pkg;
  // ==========================================================================
  // register map (printed offsets not multiples of four: index, byte = 4*index)
  localparam logic [7:0]  IDX_CLK_DIV     = 8'h40;
  localparam logic [7:0]  IDX_FRAC_HI     = 8'h41;
  localparam logic [7:0]  IDX_FRAC_MID    = 8'h42;
  localparam logic [7:0]  IDX_FRAC_LO     = 8'h43;
  localparam logic [7:0]  IDX_SYNTH_CTRL  = 8'h44;
  localparam logic [7:0]  IDX_CLOCK_CTRL  = 8'h03;
  localparam logic [7:0]  IDX_STATUS      = 8'h17;
  // ==========================================================================
  // reset values
  localparam logic [7:0]  RST_CLK_DIV     = 8'h20;
  localparam logic [23:0] RST_FRAC        = 24'h00_0000;
  localparam logic [7:0]  RST_SYNTH_CTRL  = 8'h88;
  localparam logic [7:0]  RST_CLOCK_CTRL  = 8'h03;
  // ==========================================================================
  // field positions
  localparam int AUX_DIV_LSB   = 0;
  localparam int MCLK_DIV_LSB  = 2;
  localparam int OSR_BIT       = 5;
  localparam int MIC_BIT       = 6;
  localparam int DIV_N_LSB     = 0;
  localparam int PRESC_BIT     = 4;
  localparam int BYPASS_BIT    = 6;
  localparam int ENABLE_BIT    = 7;
  localparam int FLL_BIT       = 3;
  localparam int LOCK_BIT      = 7;
  // ==========================================================================
  // timing and ratio constants
  localparam int CLK_MHZ       = 40;
  localparam int SETTLE_US     = 100;
  localparam int SETTLE_CYC    = SETTLE_US * CLK_MHZ;
  localparam int FRAC_BITS     = 24;
  localparam int N_MIN         = 6;
  localparam int N_MAX         = 12;
  localparam int POST_DIV      = 4;
endpackage : pll_cfg_pkg

// >>> clk_div_gen.sv
`timescale 1ns/1ps
// ============================================================================
// divider: period given in half cycles, toggles output accordingly
module clk_div_gen #(
  parameter int W = 6
) (
  input  wire logic         pclk,      // clock
  input  wire logic         presetn,   // async reset, low
  input  wire logic         ce,        // clock enable
  input  wire logic         run,       // divider running
  input  wire logic [W-1:0] half_cnt,  // half period in source ticks, >=1
  input  wire logic         tick,      // source tick
  output logic              clk_out    // divided clock
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         q;
  } div_state_t;
  div_state_t s_r, s_nxt;

  // a one-bit counter cannot hold a half period of two ticks or more
  if (W < 2) begin : g_bad_width
    $error("divider width must be at least two");
  end

  // count ticks, flip every half period
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt = '0;
    end else if (tick) begin
      if (s_r.cnt + W'(1) >= half_cnt) begin
        s_nxt.cnt = '0;
        s_nxt.q   = ~s_r.q;
      end else begin
        s_nxt.cnt = s_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign clk_out = s_r.q;
endmodule : clk_div_gen

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pll_cfg_pkg::*;
  // ==========================================================================
  // signals and design
  localparam int SETTLE = 8;
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] rd;
  } row_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, ref_clock_in, synth_clk_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, synth_enable, ref_div2, core_clock_node;
  logic        internal_master_clock, aux_out_clk, dac_oversample_sel;
  logic        mic_sample_rate_sel, frame_lock_loop_on, synth_locked;
  logic [3:0]  mult_int;
  logic [23:0] mult_fraction;
  int          n_fail, total_checks, per, cnt;
  int          half_div [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
  row_t        rows [6] = '{
    '{8'h41, 32'h0000_0031, 32'h0000_0031}, '{8'h42, 32'h0000_0026, 32'h0000_0026},
    '{8'h43, 32'h0000_00E9, 32'h0000_00E9}, '{8'h44, 32'h0000_00BA, 32'h0000_009A},
    '{8'h40, 32'h0000_00E0, 32'h0000_0060}, '{8'h03, 32'h0000_000B, 32'h0000_000B}};

  fractional_pll_clock_config #(.SETTLE_CYCLES(SETTLE)) i_fractional_pll_clock_config (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ref_clock_in(ref_clock_in),
    .synth_clk_tick(synth_clk_tick), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mult_int(mult_int), .mult_fraction(mult_fraction), .synth_enable(synth_enable),
    .ref_div2(ref_div2), .core_clock_node(core_clock_node),
    .internal_master_clock(internal_master_clock), .aux_out_clk(aux_out_clk),
    .dac_oversample_sel(dac_oversample_sel), .mic_sample_rate_sel(mic_sample_rate_sel),
    .frame_lock_loop_on(frame_lock_loop_on), .synth_locked(synth_locked));

  // ==========================================================================
  // clock, oscillator tick every second cycle
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) synth_clk_tick <= ~synth_clk_tick;

  // ==========================================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_per(input string name, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_per

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    r = '0;
    e = 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        r = prdata;
        e = pslverr;
        break;
      end
    end
    if (i == 50) chk("pready_seen", 32'h0000_0001, 32'h0000_0000);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // period in pclk cycles between the second and third rising edge
  task automatic measure(input bit sel, output int p);
    logic prev, cur;
    int   c, edges;
    p = 0;
    c = 0;
    edges = 0;
    prev = 1'b1;
    repeat (400) begin
      @(posedge pclk);
      cur = sel ? aux_out_clk : internal_master_clock;
      c++;
      if (cur === 1'b1 && prev === 1'b0) begin
        edges++;
        if (edges == 3) begin
          p = c;
          break;
        end
        c = 0;
      end
      prev = cur;
    end
  endtask : measure

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // watchdog: whole run is about a thousand cycles
  initial begin
    #2_000_000;
    n_fail++;
    summarize();
  end

  // ==========================================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, ref_clock_in, synth_clk_tick} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    chk("rst_mult_int", 32'h0000_0008, {28'h0, mult_int});
    chk("rst_enable", 32'h0000_0001, {31'h0, synth_enable});
    chk("rst_lock", 32'h0000_0000, {31'h0, synth_locked});
    presetn <= 1'b1;
    // register reset values
    apb(1'b0, IDX_CLK_DIV, '0, rd, err);
    chk("rst_clk_div", 32'h0000_0020, rd);
    apb(1'b0, IDX_SYNTH_CTRL, '0, rd, err);
    chk("rst_synth_ctrl", 32'h0000_0088, rd);
    apb(1'b0, IDX_FRAC_HI, '0, rd, err);
    chk("rst_frac_hi", 32'h0000_0000, rd);
    apb(1'b0, IDX_CLOCK_CTRL, '0, rd, err);
    chk("rst_clock_ctrl", 32'h0000_0003, rd);
    // table: write then read back
    foreach (rows[k]) begin
      apb(1'b1, rows[k].idx, rows[k].wd, rd, err);
      apb(1'b0, rows[k].idx, '0, rd, err);
      chk("readback", rows[k].rd, rd);
    end
    repeat (3) @(posedge pclk);
    chk("fraction", 32'h0031_26E9, {8'h0, mult_fraction});
    chk("mult_int", 32'h0000_000A, {28'h0, mult_int});
    chk("ref_div2", 32'h0000_0001, {31'h0, ref_div2});
    chk("osr", 32'h0000_0001, {31'h0, dac_oversample_sel});
    chk("mic", 32'h0000_0001, {31'h0, mic_sample_rate_sel});
    chk("frame_lock", 32'h0000_0001, {31'h0, frame_lock_loop_on});
    // lock drops on a fraction write and returns after settling
    apb(1'b1, IDX_FRAC_LO, 32'h0000_00E9, rd, err);
    @(posedge pclk);
    chk("lock_drop", 32'h0000_0000, {31'h0, synth_locked});
    for (cnt = 0; cnt < 40 && synth_locked !== 1'b1; cnt++) @(posedge pclk);
    chk("lock_settle", 32'h0000_0001, {31'h0, cnt >= SETTLE - 3 && cnt <= SETTLE + 3});
    apb(1'b1, IDX_STATUS, 32'h0000_0000, rd, err);
    apb(1'b0, IDX_STATUS, '0, rd, err);
    chk("status_lock", 32'h0000_0080, rd & 32'h0000_0080);
    // unmapped index refused
    apb(1'b0, 8'h45, '0, rd, err);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
    chk("unmapped_data", 32'h0000_0000, rd);
    // master divisor, after fixed divide by four; tick every 2 cycles
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_CLK_DIV, {27'h0, c[2:0], 2'b00}, rd, err);
      measure(1'b0, per);
      chk_per("mclk_period", POST_DIV * half_div[c], per);
    end
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, IDX_CLK_DIV, {30'h0, d[1:0]}, rd, err);
      measure(1'b1, per);
      chk_per("aux_period", 2 * (d + 1), per);
    end
    // ordered shutdown, frame-lock never raised while off
    apb(1'b1, IDX_CLOCK_CTRL, 32'h0000_0003, rd, err);
    apb(1'b1, IDX_SYNTH_CTRL, 32'h0000_00DA, rd, err);
    apb(1'b1, IDX_SYNTH_CTRL, 32'h0000_005A, rd, err);
    repeat (12) @(posedge pclk);
    chk("enable_off", 32'h0000_0000, {31'h0, synth_enable});
    chk("fll_off", 32'h0000_0000, {31'h0, frame_lock_loop_on});
    chk("lock_off", 32'h0000_0000, {31'h0, synth_locked});
    // bypass: reference pin reaches core clock node
    ref_clock_in <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("bypass_hi", 32'h0000_0001, {31'h0, core_clock_node});
    ref_clock_in <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("bypass_lo", 32'h0000_0000, {31'h0, core_clock_node});
    // mid-run reset brings registers back to their reset values
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_CLK_DIV, '0, rd, err);
    chk("rerst_clk_div", 32'h0000_0020, rd);
    apb(1'b0, IDX_SYNTH_CTRL, '0, rd, err);
    chk("rerst_synth_ctrl", 32'h0000_0088, rd);
    // clock enable low freezes the running master clock
    repeat (5) @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    rd = {31'h0, internal_master_clock};
    repeat (16) begin
      @(posedge pclk);
      chk("ce_freeze", rd, {31'h0, internal_master_clock});
    end
    ce <= 1'b1;
    summarize();
  end
endmodule : tb_top
